// ===== design/dbgtr_pkg.sv
// dbgtr_pkg: constants and types for the debug mode and trace port block
// assumes a 40 MHz pclk and an APB master using aligned 32-bit words
package dbgtr_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_SETUP = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_REASON = 8'h08;
    localparam logic [7:0] OFS_WORD = 8'h0C;
    localparam logic [7:0] OFS_INTST = 8'h10;
    localparam logic [7:0] OFS_INTMSK = 8'h14;
    // trace_setup_register fields
    localparam int SET_MODE_LSB = 0;
    localparam int SET_SPEED_LSB = 4;
    localparam int SET_DRIVE_BIT = 8;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_PAR = 2'h1;
    localparam logic [1:0] MODE_SER = 2'h2;
    localparam logic [3:0] SPEED_RST = 4'h0;
    // reset_reason_register and status fields
    localparam int REASON_WAKE_BIT = 0;
    localparam int ST_DEBUG_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_ITM_BIT = 2;
    localparam int ST_ITR_BIT = 3;
    // interrupt events
    localparam int EV_WAKE = 0;
    localparam int EV_ENTER = 1;
    localparam int EV_EXIT = 2;
    localparam int EV_OVR = 3;
    localparam int NUM_EV = 4;
    // pins and widths
    localparam int NPAD = 5;
    localparam int PAD_TCLK = 4;
    localparam int PRIO_W = 3;
    localparam int WORD_BYTES = 4;
    localparam int SER_BITS = 10;
    // pclk period and trace clock period limits in picoseconds, half period limits in pclk cycles
    localparam int CLK_PS = 25000;
    localparam int TCYC_MIN_PS = 62500;
    localparam int TCYC_MAX_PS = 500000;
    localparam int HALF_MIN = (TCYC_MIN_PS + 2 * CLK_PS - 1) / (2 * CLK_PS);
    localparam int HALF_MAX = TCYC_MAX_PS / (2 * CLK_PS);
    // debug session states
    typedef enum logic [1:0] {
        DS_NORMAL = 2'b00,
        DS_WAKE = 2'b01,
        DS_DEBUG = 2'b11
    } dbgtr_dstate_t;
endpackage : dbgtr_pkg

// ===== design/dbgtr_shift.sv
// dbgtr_shift: symbol shifter for the trace port unit
// assumes one step pulse per trace period and loads only on a step
`timescale 1ns/100ps
`default_nettype none
module dbgtr_shift #(
    parameter int BYTES = dbgtr_pkg::WORD_BYTES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clr,
    input wire logic step,
    input wire logic load,
    input wire logic serial,
    input wire logic [BYTES*8-1:0] word,
    output logic busy,
    output logic last,
    output logic [3:0] sym,
    output logic swo
);
    import dbgtr_pkg::*;
    localparam int FW = BYTES * SER_BITS;
    localparam int CW = $clog2(FW + 1);
    logic [FW-1:0] sr_r;
    logic [CW-1:0] cnt_r;
    logic ser_r;
    logic [FW-1:0] frame;

    // each byte framed as start 0, eight data bits lsb first, stop 1
    for (genvar b = 0; b < BYTES; b++) begin : g_frame
        assign frame[b*SER_BITS +: SER_BITS] = {1'b1, word[b*8 +: 8], 1'b0};
    end

    // a load on the last step keeps the stream gapless
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sr_r <= '0;
            cnt_r <= '0;
            ser_r <= 1'b0;
        end else if (clr) begin
            cnt_r <= '0;
        end else if (step && load) begin
            ser_r <= serial;
            sr_r <= serial ? frame : FW'(word);
            cnt_r <= serial ? CW'(FW) : CW'(BYTES * 2);
        end else if (step && cnt_r != '0) begin
            sr_r <= ser_r ? (sr_r >> 1) : (sr_r >> 4);
            cnt_r <= cnt_r - 1'b1;
        end
    end

    assign busy = (cnt_r != '0);
    assign last = (cnt_r <= CW'(1));
    assign sym = sr_r[3:0];
    // serial line idles high between frames
    assign swo = busy ? sr_r[0] : 1'b1;
endmodule : dbgtr_shift
`default_nettype wire

// ===== design/dbgtr_top.sv
// dbgtr_top: debug power handshake, trace port unit and pin mux
// assumes APB from pclk logic; swd_clk and debug_power_request are pins
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module dbgtr_top #(
    parameter int TRACE_BYTES = dbgtr_pkg::WORD_BYTES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic swd_clk,
    input wire logic debug_power_request,
    input wire logic system_off,
    input wire logic cpu_active,
    input wire logic cpu_halted,
    input wire logic [dbgtr_pkg::PRIO_W-1:0] halt_prio,
    input wire logic [dbgtr_pkg::PRIO_W-1:0] irq_prio,
    input wire logic itrace_valid,
    input wire logic [TRACE_BYTES*8-1:0] itrace_data,
    input wire logic [dbgtr_pkg::NPAD-1:0] gpio_out,
    input wire logic [dbgtr_pkg::NPAD-1:0] gpio_oe,
    output logic itrace_ready,
    output logic power_ack,
    output logic debug_mode,
    output logic wake_req,
    output logic irq,
    output logic irq_allow,
    output logic reg_on,
    output logic clk_on,
    output logic drive_high,
    output logic [dbgtr_pkg::NPAD-1:0] pad_out,
    output logic [dbgtr_pkg::NPAD-1:0] pad_oe
);
    import dbgtr_pkg::*;
    localparam int TW = TRACE_BYTES * 8;

    // pin synchronisers; first stages feed only the second stages
    logic swck_s1_r, swck_s2_r, swck_s3_r;
    logic req_s1_r, req_s2_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            swck_s1_r <= 1'b0;
            swck_s2_r <= 1'b0;
            swck_s3_r <= 1'b0;
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
        end else begin
            swck_s1_r <= swd_clk;
            swck_s2_r <= swck_s1_r;
            swck_s3_r <= swck_s2_r;
            req_s1_r <= debug_power_request;
            req_s2_r <= req_s1_r;
        end
    end

    // request sampled on debugger clock rise; a stopped clock holds it
    logic swck_rise;
    logic req_r;
    assign swck_rise = swck_s2_r & ~swck_s3_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_r <= 1'b0;
        end else if (swck_rise) begin
            req_r <= req_s2_r;
        end
    end

    // debug session state machine
    dbgtr_dstate_t ds_r, ds_nxt;
    always_comb begin
        ds_nxt = ds_r;
        case (ds_r)
            DS_NORMAL: begin
                if (req_r) begin
                    ds_nxt = system_off ? DS_WAKE : DS_DEBUG;
                end
            end
            DS_WAKE: begin
                ds_nxt = req_r ? DS_DEBUG : DS_NORMAL;
            end
            DS_DEBUG: begin
                if (!req_r) begin
                    ds_nxt = DS_NORMAL;
                end
            end
            default: begin
                ds_nxt = DS_NORMAL;
            end
        endcase
    end

    logic debug_mode_r, power_ack_r, wake_req_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ds_r <= DS_NORMAL;
            debug_mode_r <= 1'b0;
            power_ack_r <= 1'b0;
            wake_req_r <= 1'b0;
        end else begin
            ds_r <= ds_nxt;
            debug_mode_r <= (ds_nxt != DS_NORMAL);
            power_ack_r <= debug_mode_r;
            wake_req_r <= (ds_nxt == DS_WAKE);
        end
    end

    // APB decode; no wait cycle, read data comes from a flop loaded in the setup cycle
    logic setup, done, wr_done, rd_done;
    assign setup = psel & ~penable;
    assign done = psel & penable & pready;
    assign wr_done = done & pwrite;
    assign rd_done = done & ~pwrite;

    logic [1:0] mode_r;
    logic [3:0] speed_r;
    logic drive_r;
    logic reason_r;
    logic [NUM_EV-1:0] stat_r, mask_r, ev;
    logic itm_pend_r, itr_pend_r;
    logic sh_busy, sh_last, sh_swo;
    logic [3:0] sh_sym;
    logic [31:0] rdata;
    logic hit;

    always_comb begin
        rdata = 32'h0000_0000;
        hit = 1'b1;
        case (paddr)
            OFS_SETUP: begin
                rdata[SET_MODE_LSB +: 2] = mode_r;
                rdata[SET_SPEED_LSB +: 4] = speed_r;
                rdata[SET_DRIVE_BIT] = drive_r;
            end
            OFS_STATUS: begin
                rdata[ST_DEBUG_BIT] = debug_mode_r;
                rdata[ST_BUSY_BIT] = sh_busy;
                rdata[ST_ITM_BIT] = itm_pend_r;
                rdata[ST_ITR_BIT] = itr_pend_r;
            end
            OFS_REASON: rdata[REASON_WAKE_BIT] = reason_r;
            OFS_WORD: rdata = 32'h0000_0000;
            OFS_INTST: rdata[NUM_EV-1:0] = stat_r;
            OFS_INTMSK: rdata[NUM_EV-1:0] = mask_r;
            default: hit = 1'b0;
        endcase
    end

    // answer in the access cycle; unmapped offsets flag an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            if (setup) begin
                prdata <= pwrite ? 32'h0000_0000 : rdata;
                pslverr <= ~hit;
            end
        end
    end

    // trace setup register; drive is frozen while a debugger is attached
    logic setup_wr, mode_chg;
    assign setup_wr = wr_done && paddr == OFS_SETUP;
    assign mode_chg = setup_wr && pwdata[SET_MODE_LSB +: 2] != mode_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= MODE_OFF;
            speed_r <= SPEED_RST;
            drive_r <= 1'b0;
        end else if (setup_wr) begin
            mode_r <= pwdata[SET_MODE_LSB +: 2];
            speed_r <= pwdata[SET_SPEED_LSB +: 4];
            if (!debug_mode_r) begin
                drive_r <= pwdata[SET_DRIVE_BIT];
            end
        end
    end

    // code 3 is reserved and keeps trace off, so one form at most is live
    logic par, ser, tr_on;
    assign par = (mode_r == MODE_PAR);
    assign ser = (mode_r == MODE_SER);
    assign tr_on = par | ser;

    // half period in pclk cycles, clamped to the trace clock limits
    logic [4:0] half_len;
    always_comb begin
        half_len = 5'(HALF_MIN) + {1'b0, speed_r};
        if (half_len > 5'(HALF_MAX)) begin
            half_len = 5'(HALF_MAX);
        end
    end

    // trace clock divider; a step marks each falling trace clock edge
    logic [4:0] hc_r;
    logic tclk_r, hc_wrap, step;
    assign hc_wrap = (hc_r >= half_len - 5'h1);
    assign step = tr_on & tclk_r & hc_wrap;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hc_r <= 5'h0;
            tclk_r <= 1'b0;
        end else if (!tr_on) begin
            hc_r <= 5'h0;
            tclk_r <= 1'b0;
        end else if (hc_wrap) begin
            hc_r <= 5'h0;
            tclk_r <= ~tclk_r;
        end else begin
            hc_r <= hc_r + 5'h1;
        end
    end

    // holding words for the two trace sources
    logic [TW-1:0] itm_word_r, itr_word_r;
    logic itrace_ready_r, take, ld, ld_itr, word_wr, itm_ok;
    assign take = itrace_valid & itrace_ready_r;
    assign ld_itr = itr_pend_r & par;
    assign ld = step & sh_last & (ld_itr | itm_pend_r);
    assign word_wr = wr_done && paddr == OFS_WORD && tr_on;
    assign itm_ok = ~itm_pend_r | (ld & ~ld_itr);

    // instruction trace is accepted and kept only in parallel mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            itr_pend_r <= 1'b0;
            itr_word_r <= '0;
            itrace_ready_r <= 1'b0;
        end else begin
            itrace_ready_r <= par & ~itr_pend_r & ~take;
            if (take) begin
                itr_pend_r <= 1'b1;
                itr_word_r <= itrace_data;
            end else if (!par || (ld && ld_itr)) begin
                itr_pend_r <= 1'b0;
            end
        end
    end

    // instrumentation words from software; a full holder drops the write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            itm_pend_r <= 1'b0;
            itm_word_r <= '0;
        end else if (word_wr && itm_ok) begin
            itm_pend_r <= 1'b1;
            itm_word_r <= pwdata[TW-1:0];
        end else if (ld && !ld_itr) begin
            itm_pend_r <= 1'b0;
        end
    end

    dbgtr_shift #(
        .BYTES(TRACE_BYTES)
    ) u_shift (
        .clk(pclk),
        .rstn(presetn),
        .clr(mode_chg),
        .step(step),
        .load(ld),
        .serial(ser),
        .word(ld_itr ? itr_word_r : itm_word_r),
        .busy(sh_busy),
        .last(sh_last),
        .sym(sh_sym),
        .swo(sh_swo)
    );

    // pin mux: trace takes pins from general logic only while enabled
    logic [NPAD-1:0] use_t, val_t;
    for (genvar i = 0; i < NPAD; i++) begin : g_pad
        if (i == PAD_TCLK) begin : g_ck
            assign use_t[i] = par;
            assign val_t[i] = tclk_r;
        end else if (i == 0) begin : g_d0
            assign use_t[i] = par | ser;
            assign val_t[i] = ser ? sh_swo : sh_sym[0];
        end else begin : g_dn
            assign use_t[i] = par;
            assign val_t[i] = sh_sym[i];
        end
    end

    logic [NPAD-1:0] pad_out_r, pad_oe_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out_r <= '0;
            pad_oe_r <= '0;
        end else begin
            pad_out_r <= (use_t & val_t) | (~use_t & gpio_out);
            pad_oe_r <= use_t | gpio_oe;
        end
    end

    // events, reason flag and interrupt; a set beats a same-cycle clear
    logic rd_intst, wake_ev;
    assign rd_intst = rd_done && paddr == OFS_INTST;
    assign wake_ev = (ds_r == DS_NORMAL) && (ds_nxt == DS_WAKE);
    assign ev[EV_WAKE] = wake_ev;
    assign ev[EV_ENTER] = (ds_r == DS_NORMAL) && (ds_nxt != DS_NORMAL);
    assign ev[EV_EXIT] = (ds_r != DS_NORMAL) && (ds_nxt == DS_NORMAL);
    assign ev[EV_OVR] = word_wr & ~itm_ok;

    logic irq_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= '0;
            mask_r <= '0;
            reason_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            stat_r <= (stat_r & ~{NUM_EV{rd_intst}}) | ev;
            if (wr_done && paddr == OFS_INTMSK) begin
                mask_r <= pwdata[NUM_EV-1:0];
            end
            reason_r <= wake_ev | (reason_r & ~(wr_done && paddr == OFS_REASON
                && pwdata[REASON_WAKE_BIT]));
            irq_r <= |(stat_r & mask_r);
        end
    end

    // power manager and real-time halting; lower number is higher priority
    logic reg_on_r, clk_on_r, irq_allow_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_on_r <= 1'b1;
            clk_on_r <= 1'b1;
            irq_allow_r <= 1'b1;
        end else begin
            reg_on_r <= cpu_active | debug_mode_r | ~system_off;
            clk_on_r <= cpu_active | debug_mode_r | tr_on | sh_busy;
            irq_allow_r <= ~cpu_halted | (irq_prio < halt_prio);
        end
    end

    assign itrace_ready = itrace_ready_r;
    assign power_ack = power_ack_r;
    assign debug_mode = debug_mode_r;
    assign wake_req = wake_req_r;
    assign irq = irq_r;
    assign irq_allow = irq_allow_r;
    assign reg_on = reg_on_r;
    assign clk_on = clk_on_r;
    assign drive_high = drive_r;
    assign pad_out = pad_out_r;
    assign pad_oe = pad_oe_r;

    // checks on the block's own registers
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    debug_enter_a: assert property ($rose(req_r) |=> debug_mode_r ##1 power_ack_r)
        else $error("debug mode not entered after power request");
    debug_leave_a: assert property ($fell(req_r) |=> !debug_mode_r ##1 !power_ack_r)
        else $error("debug mode kept after request dropped");
    wake_flag_a: assert property ($rose(req_r) && system_off
        |=> wake_req_r && reason_r ##1 !wake_req_r)
        else $error("wake from off not flagged");
    tclk_pace_a: assert property ($changed(tclk_r) && $past(tr_on)
        |-> $past(hc_r) >= $past(half_len) - 5'h1)
        else $error("trace clock toggled early");
    tclk_pin_a: assert property (par |=> pad_oe_r[PAD_TCLK]
        && pad_out_r[PAD_TCLK] == $past(tclk_r))
        else $error("trace clock not on its pin");
    swo_pin_a: assert property (ser |=> pad_oe_r[0] && pad_out_r[0] == $past(sh_swo)
        && pad_out_r[1] == $past(gpio_out[1]))
        else $error("serial output not on shared pin");
    itr_serial_a: assert property (!par |=> !itrace_ready_r ##1 !itr_pend_r)
        else $error("instruction trace taken outside parallel mode");
    drive_lock_a: assert property (debug_mode_r |=> $stable(drive_r))
        else $error("drive changed during debug");
    rt_irq_a: assert property (cpu_halted && irq_prio < halt_prio |=> irq_allow_r)
        else $error("higher priority interrupt blocked while halted");
    pm_on_a: assert property (debug_mode_r |=> reg_on_r && clk_on_r)
        else $error("power resources off in debug mode");
    irq_level_a: assert property (|(stat_r & mask_r) |=> irq_r)
        else $error("interrupt missing for unmasked status");
    stat_clear_a: assert property (rd_intst && ev == '0 |=> stat_r == '0)
        else $error("status not cleared by read");

    wake_c: cover property ($rose(wake_req_r));
    par_word_c: cover property (par && $fell(sh_busy));
    ser_word_c: cover property (ser && $fell(sh_busy));
    overrun_c: cover property (ev[EV_OVR]);
endmodule : dbgtr_top
`default_nettype wire

// ===== sim/dbgtr_probe.sv
// dbgtr_probe: external debug probe model, power request and trace capture
// assumes pad 4 carries the trace clock and pads 0..3 the trace nibble
`timescale 1ns/100ps
`default_nettype none
module dbgtr_probe (
    output logic swd_clk,
    output logic power_req,
    input wire logic [4:0] pad_out,
    input wire logic [4:0] pad_oe
);
    logic [31:0] word_r;
    int nib_count;
    initial begin
        swd_clk = 1'b0;
        power_req = 1'b0;
        word_r = 32'h0;
        nib_count = 0;
    end
    // clock runs only inside a frame, so the request is seen only there
    task automatic power(input logic v);
        #7 power_req = v;
        repeat (4) begin
            #100 swd_clk = 1'b1;
            #100 swd_clk = 1'b0;
        end
    endtask : power
    // nibbles change on the falling trace clock, so take them on the rise
    always @(posedge pad_out[4]) begin
        if (pad_oe[4]) begin
            word_r <= {pad_out[3:0], word_r[31:4]};
            nib_count <= nib_count + 1;
        end
    end
endmodule : dbgtr_probe
`default_nettype wire

// ===== sim/testbench.sv
// testbench: scenario tasks for the debug mode and trace port block
// assumes the probe model beside the design and APB at 40 MHz
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import dbgtr_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, system_off, cpu_halted, itrace_valid;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, itrace_data;
    logic pready, pslverr, swd_clk, preq, itrace_ready, power_ack, debug_mode, wake_req, irq;
    logic irq_allow, reg_on, clk_on, drive_high, wake_seen, ready_seen, e, cpu_active;
    logic [PRIO_W-1:0] halt_prio, irq_prio;
    logic [NPAD-1:0] gpio_out, gpio_oe, pad_out, pad_oe;
    int fail_count = 0;
    int n_compared = 0;
    dbgtr_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .swd_clk(swd_clk), .debug_power_request(preq),
        .system_off(system_off), .cpu_active(cpu_active), .cpu_halted(cpu_halted),
        .halt_prio(halt_prio), .irq_prio(irq_prio), .itrace_valid(itrace_valid),
        .itrace_data(itrace_data), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .itrace_ready(itrace_ready), .power_ack(power_ack), .debug_mode(debug_mode),
        .wake_req(wake_req), .irq(irq), .irq_allow(irq_allow), .reg_on(reg_on),
        .clk_on(clk_on), .drive_high(drive_high), .pad_out(pad_out), .pad_oe(pad_oe));
    dbgtr_probe probe (.swd_clk(swd_clk), .power_req(preq), .pad_out(pad_out),
        .pad_oe(pad_oe));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // sticky monitors catch one-cycle pulses between checks
    always @(posedge pclk) begin
        if (wake_req === 1'b1) wake_seen <= 1'b1;
        if (itrace_ready === 1'b1) ready_seen <= 1'b1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // answer taken at the very edge where pready is sampled high
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk(32'h0, 32'h1);
    endtask : apb
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : settle
    task automatic t_reset;
        apb(0, OFS_SETUP, 0); chk(q, 32'h0);
        apb(0, OFS_REASON, 0); chk(q, 32'h0);
        apb(0, 8'h40, 0); chk({q[30:0], e}, 32'h1);
        chk({reg_on, clk_on, irq_allow}, 32'h7);
        chk({pad_oe, pad_out}, {22'h0, 5'h00, 5'h0A});
    endtask : t_reset
    task automatic t_wake;
        apb(1, OFS_INTMSK, 32'hF);
        system_off <= 1'b1;
        probe.power(1'b1);
        for (int i = 0; i < 50 && power_ack !== 1'b1; i++) @(posedge pclk);
        #1 chk({wake_seen, debug_mode, power_ack, irq}, 32'hF);
        @(posedge pclk);
        system_off <= 1'b0;
        // drive select is frozen while a debugger is attached
        apb(1, OFS_SETUP, 32'h100);
        chk(drive_high, 1'b0);
        apb(0, OFS_REASON, 0); chk(q, 32'h1);
        apb(1, OFS_REASON, 32'h1);
        apb(0, OFS_REASON, 0); chk(q, 32'h0);
        apb(0, OFS_INTST, 0); chk(q, 32'h3);
        settle(2); chk(irq, 1'b0);
        settle(400); chk(debug_mode, 1'b1);
    endtask : t_wake
    task automatic t_release;
        probe.power(1'b0);
        settle(4);
        chk({debug_mode, power_ack}, 32'h0);
        apb(0, OFS_INTST, 0); chk(q, 32'h4);
        // nothing needs power once cpu idles in the off state
        cpu_active <= 1'b0;
        system_off <= 1'b1;
        settle(3);
        chk({reg_on, clk_on}, 32'h0);
        @(posedge pclk);
        cpu_active <= 1'b1;
        system_off <= 1'b0;
    endtask : t_release
    task automatic t_par;
        int c;
        apb(1, OFS_SETUP, 32'h121);
        apb(0, OFS_SETUP, 0); chk(q, 32'h121);
        chk(drive_high, 1'b1);
        // trace clock runs free, so count nibbles only from the write onwards
        apb(1, OFS_WORD, 32'h87654321);
        c = probe.nib_count;
        for (int i = 0; i < 2000 && probe.nib_count < c + 8; i++) @(posedge pclk);
        chk(probe.word_r, 32'h87654321);
        chk(pad_oe, 5'h1F);
        c = probe.nib_count;
        itrace_valid <= 1'b1;
        do @(posedge pclk); while (itrace_ready !== 1'b1);
        itrace_valid <= 1'b0;
        for (int i = 0; i < 2000 && probe.nib_count < c + 8; i++) @(posedge pclk);
        chk(probe.word_r, 32'h0FEDCBA9);
    endtask : t_par
    task automatic t_ser;
        logic [39:0] f;
        apb(1, OFS_SETUP, 32'h002);
        // ready may linger one cycle after parallel mode ends
        repeat (2) @(posedge pclk);
        ready_seen <= 1'b0;
        itrace_valid <= 1'b1;
        settle(300);
        chk({ready_seen, pad_oe}, {1'b0, 5'h01});
        chk(pad_out[0], 1'b1);
        @(posedge pclk);
        itrace_valid <= 1'b0;
        // one word on the serial line: find the start bit, sample bit centres
        apb(1, OFS_WORD, 32'h3CA5_5AC3);
        for (int i = 0; i < 200 && pad_out[0] !== 1'b0; i++) @(posedge pclk);
        repeat (2) @(posedge pclk);
        for (int i = 0; i < 40; i++) begin
            f = {pad_out[0], f[39:1]};
            repeat (4) @(posedge pclk);
        end
        chk({12'h0, f[39:20]}, {12'h0, 1'b1, 8'h3C, 1'b0, 1'b1, 8'hA5, 1'b0});
        chk({12'h0, f[19:0]}, {12'h0, 1'b1, 8'h5A, 1'b0, 1'b1, 8'hC3, 1'b0});
    endtask : t_ser
    task automatic t_halt;
        cpu_halted <= 1'b1;
        halt_prio <= 3'h4;
        irq_prio <= 3'h2;
        settle(3); chk(irq_allow, 1'b1);
        @(posedge pclk);
        irq_prio <= 3'h6;
        settle(3); chk(irq_allow, 1'b0);
        @(posedge pclk);
        cpu_halted <= 1'b0;
    endtask : t_halt
    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    initial begin
        {presetn, psel, penable, pwrite, system_off, cpu_halted, itrace_valid} = '0;
        {wake_seen, ready_seen, paddr, pwdata} = '0;
        halt_prio = 3'h0;
        irq_prio = 3'h0;
        cpu_active = 1'b1;
        itrace_data = 32'h0FEDCBA9;
        gpio_out = 5'h0A;
        gpio_oe = 5'h00;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_wake();
        t_release();
        t_par();
        t_ser();
        t_halt();
        test_done();
    end
    // watchdog well beyond the expected run of little more than a thousand cycles
    initial begin
        repeat (60000) @(posedge pclk);
        fail_count++;
        test_done();
    end
endmodule : testbench
`default_nettype wire
